//--- shared/cit_pkg.sv
// constants, types and state record of the calibrated interval tick block
package cit_pkg;

    // ---------------------------------------------------------------
    // clocking and measurement step
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000; // system clock rate
    localparam int unsigned DOC_CLK_HZ = 10_000_000; // rate the step was sized at
    localparam int unsigned DOC_STEP_CLKS = 7; // clocks per step at that rate
    localparam int unsigned MEAS_STEP_NS = 700; // one measurement step, ns
    // least time, rounded up to whole cycles
    localparam int unsigned MEAS_STEP_CYC =
        (MEAS_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned DIV_W = 5; // step divider width
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MEAS_STEP_CYC - 1);

    // ---------------------------------------------------------------
    // measurement counter and conversion
    // ---------------------------------------------------------------
    localparam int unsigned MEAS_W = 16; // measurement counter width
    localparam logic [15:0] WAKEUP_OFFSET = 16'h0028; // wake-up offset, 40
    localparam logic [15:0] MEAS_PRESET = WAKEUP_OFFSET + 16'h0001;
    localparam logic [15:0] MEAS_MAX = 16'hFFFF; // counter saturates here
    localparam logic [15:0] MEAS_ONE = 16'h0001;
    localparam logic [7:0] EVT_BASE = 8'h42; // 66
    localparam logic [7:0] EVT_ADJ_LIM = 8'h1C; // 28
    localparam logic [7:0] EVT_MIN = 8'h1B; // 27
    localparam logic [7:0] EVT_MAX = 8'h24; // 36
    localparam logic [7:0] EVT_ONE = 8'h01;

    // ---------------------------------------------------------------
    // interval selection, in 100 ms units
    // ---------------------------------------------------------------
    localparam logic [2:0] INTVL_MIN = 3'h1; // 100 ms
    localparam logic [2:0] INTVL_MAX = 3'h5; // 500 ms
    localparam logic [2:0] INTVL_ONE = 3'h1;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        CIT_ST_CLEAR = 4'h1,
        CIT_ST_MEASURE = 4'h2,
        CIT_ST_CONVERT = 4'h4,
        CIT_ST_RUN = 4'h8
    } cit_state_t;

    // result of the last calibration
    typedef struct packed {
        logic [7:0] events_per_100ms;
        logic [MEAS_W-1:0] period_measure_count;
    } cit_calib_t;

    // whole state of the block
    typedef struct packed {
        cit_state_t state;
        logic [DIV_W-1:0] div;
        logic [MEAS_W-1:0] meas;
        logic [7:0] hund;
        logic [2:0] intv;
        logic [2:0] sel;
        logic [7:0] evcnt;
        logic led;
        logic tick;
    } cit_regs_t;

    localparam cit_regs_t CIT_REGS_RST = '{
        state: CIT_ST_CLEAR,
        div: '0,
        meas: '0,
        hund: '0,
        intv: INTVL_MIN,
        sel: INTVL_MIN,
        evcnt: '0,
        led: 1'b0,
        tick: 1'b0
    };

endpackage : cit_pkg

//--- logic/cit_interval_tick.sv
// calibrated 100 ms time base and led interval timer
//
// Contract
// - clear watchdog, count steps until event
// - one count step equals 0.7 us
// - measurement counter is 16 bits wide
// - event period spans about 2.8 to 3.8 ms
// - loaded event count stays within 27..36
// - intermediate value is count divided by 128
// - candidate is 66 minus intermediate value
// - candidates below 28 get one added
// - boundaries 5194 down to 3968; below gives 36
// - conversion finishes within 7 clocks
// - recalibrate at every new 100 ms count
// - preset counter to offset 40 plus one
// - events decrement 100 ms counter, then interval
// - interval expiry toggles led and reloads
// - interval 100..500 ms, key advances, wraps
`timescale 1ns/1ps
`default_nettype none

module cit_interval_tick
    import cit_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // event sources
    input wire logic i_watchdog_interval_event,
    input wire logic i_key_press_event,
    // watchdog control
    output logic o_watchdog_clear,
    // time base and led
    output logic o_tick_100ms,
    output logic o_led,
    output logic [2:0] o_interval_sel,
    output logic o_measuring,
    // calibration result
    output var cit_calib_t o_calib
);

    // ---------------------------------------------------------------
    // conversion from measured count to events per 100 ms
    // ---------------------------------------------------------------
    function automatic logic [7:0] cit_convert(input logic [MEAS_W-1:0] cnt);
        logic [MEAS_W-1:0] dbl;
        logic [7:0] cand;
        dbl = {cnt[MEAS_W-2:0], 1'b0}; // shift left, upper byte = cnt/128
        cand = EVT_BASE - dbl[MEAS_W-1:8];
        // very long periods, or a top bit lost to the shift, would wrap
        // the subtraction: force the low end so the clamp gives 27
        if (cnt[MEAS_W-1] || (dbl[MEAS_W-1:8] > EVT_BASE))
        begin
            cand = '0;
        end
        // close the gap at the low end
        if (cand < EVT_ADJ_LIM)
        begin
            cand = cand + EVT_ONE;
        end
        // keep inside the legal window
        if (cand < EVT_MIN)
        begin
            cand = EVT_MIN;
        end
        else if (cand > EVT_MAX)
        begin
            cand = EVT_MAX;
        end
        return cand;
    endfunction : cit_convert

    // ---------------------------------------------------------------
    // state record
    // ---------------------------------------------------------------
    cit_regs_t r_q; // registered state
    cit_regs_t r_d; // next state
    logic [7:0] conv_val; // conversion of the current count

    assign conv_val = cit_convert(r_q.meas);

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb
    begin
        r_d = r_q;
        r_d.tick = 1'b0; // tick lasts one cycle
        unique case (r_q.state)
            // watchdog cleared this cycle, counter preset
            CIT_ST_CLEAR:
            begin
                r_d.meas = MEAS_PRESET;
                r_d.div = '0;
                r_d.state = CIT_ST_MEASURE;
            end
            // count steps until the next event
            CIT_ST_MEASURE:
            begin
                if (i_watchdog_interval_event)
                begin
                    r_d.state = CIT_ST_CONVERT;
                end
                else if (r_q.div == DIV_LAST)
                begin
                    // one step is 0.7 us of elapsed time
                    r_d.div = '0;
                    // 16-bit count, saturating past the longest period
                    if (r_q.meas != MEAS_MAX)
                    begin
                        r_d.meas = r_q.meas + MEAS_ONE;
                    end
                end
                else
                begin
                    r_d.div = r_q.div + DIV_W'(1);
                end
            end
            // single-cycle conversion and load
            CIT_ST_CONVERT:
            begin
                r_d.evcnt = conv_val;
                // the event that ended measurement is the first one counted
                r_d.hund = conv_val - EVT_ONE;
                r_d.state = CIT_ST_RUN;
            end
            // count events down
            CIT_ST_RUN:
            begin
                if (i_watchdog_interval_event)
                begin
                    if (r_q.hund == EVT_ONE)
                    begin
                        // 100 ms expired: tick and recalibrate
                        r_d.hund = '0;
                        r_d.tick = 1'b1;
                        r_d.state = CIT_ST_CLEAR;
                        if (r_q.intv == INTVL_ONE)
                        begin
                            // interval done: toggle and reload
                            r_d.led = ~r_q.led;
                            r_d.intv = r_q.sel;
                        end
                        else
                        begin
                            r_d.intv = r_q.intv - INTVL_ONE;
                        end
                    end
                    else
                    begin
                        r_d.hund = r_q.hund - EVT_ONE;
                    end
                end
            end
        endcase
        // key press advances the selection, wrapping
        if (i_key_press_event)
        begin
            if (r_q.sel == INTVL_MAX)
            begin
                r_d.sel = INTVL_MIN;
            end
            else
            begin
                r_d.sel = r_q.sel + INTVL_ONE;
            end
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            r_q <= CIT_REGS_RST; // counters clear except interval count at 1, led off, watchdog clear first
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_watchdog_clear = (r_q.state == CIT_ST_CLEAR);
    assign o_tick_100ms = r_q.tick;
    assign o_led = r_q.led;
    assign o_interval_sel = r_q.sel;
    assign o_measuring = (r_q.state == CIT_ST_MEASURE);
    assign o_calib = '{events_per_100ms: r_q.evcnt, period_measure_count: r_q.meas};

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cit_cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    // clear is followed by a preset measurement
    clear_preset_a: assert property (
        r_q.state == CIT_ST_CLEAR |=> r_q.state == CIT_ST_MEASURE
            && r_q.meas == 16'h0029 && r_q.div == '0)
        else $error("counter not preset after watchdog clear");

    // watchdog clear lasts exactly one cycle
    clear_pulse_a: assert property (
        o_watchdog_clear |=> !o_watchdog_clear)
        else $error("watchdog clear held too long");

    // step count advances once per 28 clocks
    step_advance_a: assert property (
        (r_q.state == CIT_ST_MEASURE && !i_watchdog_interval_event
            && r_q.div == 5'h00 && r_q.meas != MEAS_MAX)
        ##1 (!i_watchdog_interval_event)[*8]
        |-> $stable(r_q.meas))
        else $error("count advanced early");

    step_period_a: assert property (
        (r_q.state == CIT_ST_MEASURE && r_q.div == 5'h1B
            && !i_watchdog_interval_event && r_q.meas != MEAS_MAX)
        |=> r_q.meas == $past(r_q.meas) + 16'h0001 && r_q.div == 5'h00)
        else $error("count step wrong");

    // conversion done two clocks after the event
    convert_time_a: assert property (
        r_q.state == CIT_ST_MEASURE && i_watchdog_interval_event
        |=> r_q.state == CIT_ST_CONVERT ##1 r_q.state == CIT_ST_RUN)
        else $error("conversion too slow");

    // loaded count inside the window
    count_range_a: assert property (
        $rose(r_q.state == CIT_ST_RUN)
        |-> r_q.evcnt >= 8'h1B && r_q.evcnt <= 8'h24
            && r_q.hund == r_q.evcnt - 8'h01)
        else $error("event count out of range");

    // loaded count holds outside conversion
    count_hold_a: assert property (
        r_q.state != CIT_ST_CONVERT |=> $stable(r_q.evcnt))
        else $error("event count changed outside conversion");

    // edge of the table
    long_period_a: assert property (
        r_q.state == CIT_ST_CONVERT && r_q.meas >= 16'd5194
        |=> r_q.evcnt == 8'h1B)
        else $error("long period not mapped to 27");

    short_period_a: assert property (
        r_q.state == CIT_ST_CONVERT && r_q.meas < 16'd3968
        |=> r_q.evcnt == 8'h24)
        else $error("short period not mapped to 36");

    // expiry ticks and clears the watchdog in the same cycle
    tick_expiry_a: assert property (
        r_q.state == CIT_ST_RUN && i_watchdog_interval_event
            && r_q.hund == 8'h01
        |=> o_tick_100ms && o_watchdog_clear ##1 !o_tick_100ms)
        else $error("missing tick or recalibration");

    // no tick without an expiring event
    tick_cause_a: assert property (
        o_tick_100ms |-> $past(r_q.state == CIT_ST_RUN)
            && $past(i_watchdog_interval_event))
        else $error("tick without expiry");

    // led toggles only when the interval ends
    led_toggle_a: assert property (
        $changed(o_led) |-> $past(r_q.intv) == 3'h1 && o_tick_100ms
            && r_q.intv == $past(r_q.sel))
        else $error("led toggled outside interval end");

    // selection wraps
    sel_wrap_a: assert property (
        i_key_press_event && r_q.sel == 3'h5 |=> r_q.sel == 3'h1)
        else $error("selection did not wrap");

    // each key press below selection 5 steps the selection by one
    key_step_a: assert property (
        i_key_press_event && r_q.sel != 3'h5 |=> r_q.sel == $past(r_q.sel) + 3'h1)
        else $error("selection did not advance");

    // interval count stays a legal selection
    intv_range_a: assert property (
        r_q.intv >= 3'h1 && r_q.intv <= 3'h5)
        else $error("interval count out of range");

    // reset leaves block at measurement start
    reset_state_a: assert property (
        disable iff (1'b0) $past(i_sys_rst)
        |-> r_q.state == CIT_ST_CLEAR && !o_led && r_q.sel == 3'h1)
        else $error("wrong state after reset");

    // scenarios
    full_cycle_c: cover property (o_tick_100ms);
    led_flip_c: cover property ($changed(o_led));
    wrap_c: cover property (i_key_press_event && r_q.sel == 3'h5);
    long_meas_c: cover property (r_q.state == CIT_ST_CONVERT && r_q.meas > 16'd5000);

endmodule : cit_interval_tick

`default_nettype wire

//--- dv/cit_wdt_model.sv
// watchdog interval event source model for the interval tick bench
`timescale 1ns/1ps
`default_nettype none

module cit_wdt_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // timing set by the bench, in cycles
    input wire logic [31:0] i_first_cyc,
    input wire logic [31:0] i_run_cyc,
    // watchdog side
    input wire logic i_watchdog_clear,
    output logic o_watchdog_interval_event
);
    logic [31:0] cnt_q; // cycles since the last clear

    // ---------------------------------------------------------------
    // counter restarts on every watchdog clear
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst || i_watchdog_clear)
        begin
            cnt_q <= 32'h1; // clear restarts the period
        end
        else
        begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    // one-cycle events: first after the clear, then a steady train
    assign o_watchdog_interval_event = (cnt_q >= i_first_cyc) &&
        ((cnt_q - i_first_cyc) % i_run_cyc == 32'h0);

endmodule : cit_wdt_model
`default_nettype wire

//--- dv/calibrated_interval_tick_tb.sv
// self-checking bench of the calibrated interval tick block
`timescale 1ns/1ps
`default_nettype none

module calibrated_interval_tick_tb;
    import cit_pkg::*;
    localparam int unsigned LIMIT = 100_000; // cycle ceiling
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_key_press_event = 1'b0;
    logic [31:0] first_cyc = 32'hFFFF_FFFF; // measuring event time
    logic [31:0] run_cyc = 32'h5; // event spacing when running
    logic evt, wd_clear, tick, led, meas_on;
    logic [2:0] sel;
    cit_calib_t calib;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] lfsr = 32'h625B_4A47;
    // short periods keep the run brief; first two sit at the preset and one step on
    logic [15:0] corner [6] = '{16'h0029, 16'h002A, 16'h01F0, 16'h0100, 16'h0080, 16'h0200};

    always #12.5 i_clk_sys = ~i_clk_sys;

    cit_interval_tick dut (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_watchdog_interval_event(evt), .i_key_press_event(i_key_press_event),
        .o_watchdog_clear(wd_clear), .o_tick_100ms(tick), .o_led(led),
        .o_interval_sel(sel), .o_measuring(meas_on), .o_calib(calib)
    );
    cit_wdt_model wdt (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_first_cyc(first_cyc),
        .i_run_cyc(run_cyc), .i_watchdog_clear(wd_clear), .o_watchdog_interval_event(evt)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // events per 100 ms from a measured count
    function automatic logic [7:0] exp_evt(input logic [15:0] m);
        logic [7:0] e;
        e = EVT_BASE - m[14:7]; // shift left, upper byte
        if (e < EVT_ADJ_LIM)
        begin
            e = e + 8'h01; // fill the gap at 26 and 27
        end
        if (e < EVT_MIN) e = EVT_MIN; // clamp low
        if (e > EVT_MAX) e = EVT_MAX; // clamp high
        return e;
    endfunction : exp_evt

    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_flag(input string what, input logic exp, input logic got);
        chk_val(what, {15'h0, exp}, {15'h0, got});
    endtask : chk_flag

    task automatic report_and_stop();
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // hang guard
    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        logic [15:0] m;
        logic [7:0] e;
        logic [2:0] esel;
        logic [2:0] eintv;
        logic eled;
        int n;
        esel = 3'h1;
        eintv = 3'h1;
        eled = 1'b0;
        repeat (20) @(negedge i_clk_sys);
        chk_flag("wd_clear", 1'b1, wd_clear);
        chk_flag("led", 1'b0, led);
        chk_val("sel", 16'h1, {13'h0, sel});
        chk_val("events", 16'h0, {8'h0, calib.events_per_100ms});
        for (int i = 0; i < 8; i++)
        begin
            lfsr = lfsr_next(lfsr);
            m = (i < 6) ? corner[i] : 16'(32'h29 + lfsr % 32'h180); // corner or random
            first_cyc = 32'd28 * (32'(m) - 32'd41) + 32'd15; // mid step
            run_cyc = 32'h3 + (lfsr >> 8) % 32'h8; // prompt or slow events
            if (i == 0)
            begin
                i_sys_rst = 1'b0;
                @(negedge i_clk_sys);
                chk_flag("measuring", 1'b1, meas_on);
                chk_val("preset", 16'h0029, calib.period_measure_count);
            end
            i_key_press_event = 1'b1; // one press per round
            @(negedge i_clk_sys);
            i_key_press_event = 1'b0;
            esel = (esel == 3'h5) ? 3'h1 : esel + 3'h1;
            @(negedge i_clk_sys);
            chk_val("sel", {13'h0, esel}, {13'h0, sel});
            while (!(meas_on && evt)) @(negedge i_clk_sys);
            e = exp_evt(m);
            repeat (2) @(negedge i_clk_sys);
            chk_val("count", m, calib.period_measure_count);
            chk_val("events", {8'h0, e}, {8'h0, calib.events_per_100ms});
            n = 1; // measuring event counts as first
            @(negedge i_clk_sys);
            while (!tick)
            begin
                if (evt) n++;
                @(negedge i_clk_sys);
            end
            chk_val("tick_events", {8'h0, e}, 16'(n));
            if (eintv == 3'h1)
            begin
                eled = ~eled;
                eintv = esel; // reload with selection
            end
            else
            begin
                eintv = eintv - 3'h1;
            end
            chk_flag("led", eled, led);
            chk_flag("wd_clear", 1'b1, wd_clear);
            @(negedge i_clk_sys);
            chk_flag("tick_width", 1'b0, tick);
            chk_flag("remeasure", 1'b1, meas_on);
        end
        report_and_stop();
    end

endmodule : calibrated_interval_tick_tb
`default_nettype wire
